//--- hw/cpw_timer.sv
`timescale 1ns/1ps
module cpw_timer
	import cpw_pkg::*;
#(
	// Width of the cascaded counter.
	parameter int COUNT_WIDTH = 16
)
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        srst,
	// Control.
	input  wire logic [1:0]  mode_sel,
	input  wire logic        cascade_start_bit,
	input  wire logic        event_sel,
	input  wire logic        count_tick,
	input  wire logic        output_flop_initial,
	input  wire logic        init_load,
	// Byte writes of period and width.
	input  wire logic        period_low_wr,
	input  wire logic        period_high_wr,
	input  wire logic        width_low_wr,
	input  wire logic        width_high_wr,
	input  wire logic [7:0]  wr_data,
	// External event pin.
	input  wire logic        event_pin,
	// Status and outputs.
	output logic [15:0] count_value,
	output logic        timer_match_interrupt,
	output logic        pulse_output_pin,
	output logic        warm_range_ok
);
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [15:0] period_reg;
	logic [15:0] width_reg;
	logic        flop_reg;
	logic        irq_reg;
	logic        ev_s1_reg;
	logic        ev_s2_reg;
	logic        ev_prev_reg;
	logic        range_ok_reg;

	// The byte strobes split period and width into two halves of eight bits.
	if (COUNT_WIDTH != 16) begin : g_width_check
		$error("cpw_timer serves only a sixteen-bit cascade");
	end

	wire range_low_ok  = (period_reg >= CPW_WARM_MIN); // [RULE19]
	wire range_high_ok = (period_reg <= CPW_WARM_MAX); // [RULE19]

	wire warm_mode  = (mode_sel == CPW_MODE_WARM_LO) || (mode_sel == CPW_MODE_WARM_HI); // [RULE13]
	wire event_fall = ev_prev_reg & ~ev_s2_reg; // [RULE4]
	wire step       = cascade_start_bit & (event_sel ? event_fall : count_tick); // [RULE1]
	wire width_hit  = !warm_mode && (cnt_reg == width_reg); // [RULE2] [RULE9]
	wire period_hit = warm_mode
		? (cnt_reg[15:CPW_HIGH_LSB] == period_reg[15:CPW_HIGH_LSB]) // [RULE15]
		: (cnt_reg == period_reg); // [RULE9]
	wire match_end  = step && period_hit; // [RULE3] [RULE16]
	wire flop_flip  = step && !warm_mode && (period_hit || width_hit); // [RULE2] [RULE3]

	assign cnt_next = match_end ? CPW_CNT_RESET : (step ? cnt_reg + 16'h0001 : cnt_reg); // [RULE1]

	always_ff @(posedge clk) begin
		if (srst) begin
			ev_s1_reg   <= 1'b1;
			ev_s2_reg   <= 1'b1;
			ev_prev_reg <= 1'b1;
		end else begin
			ev_s1_reg   <= event_pin;
			ev_s2_reg   <= ev_s1_reg;
			ev_prev_reg <= ev_s2_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_reg <= CPW_CNT_RESET;
			irq_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			irq_reg <= match_end; // [RULE3] [RULE16]
		end
	end

	// Unbuffered byte writes take part in comparison from the next cycle.
	always_ff @(posedge clk) begin
		if (srst) begin
			period_reg <= CPW_REG_RESET;
			width_reg  <= CPW_REG_RESET;
		end else begin
			if (period_low_wr)  period_reg[7:0]  <= wr_data; // [RULE9]
			if (period_high_wr) period_reg[15:8] <= wr_data;
			if (width_low_wr)   width_reg[7:0]   <= wr_data;
			if (width_high_wr)  width_reg[15:8]  <= wr_data;
		end
	end

	// The flop only moves on a match or an explicit load, so a stop without a load holds it.
	always_ff @(posedge clk) begin
		if (srst) begin
			flop_reg <= 1'b0; // [RULE5]
		end else if (init_load && !cascade_start_bit) begin
			flop_reg <= output_flop_initial; // [RULE5] [RULE12]
		end else if (flop_flip) begin
			flop_reg <= ~flop_reg; // [RULE2] [RULE3] [RULE11]
		end
	end

	assign count_value           = cnt_reg;
	assign timer_match_interrupt = irq_reg;
	assign pulse_output_pin      = ~flop_reg; // [RULE6]
	assign warm_range_ok         = range_ok_reg;

	// The range flag is a registered status that follows the period one cycle later.
	always_ff @(posedge clk) begin
		if (srst) begin
			range_ok_reg <= 1'b0;
		end else begin
			range_ok_reg <= range_low_ok && range_high_ok; // [RULE19]
		end
	end

	// A period match is a qualifying step followed by a cleared count with the request.
	sequence s_period_step;
		step && period_hit;
	endsequence

	sequence s_match_done;
		(cnt_reg == CPW_CNT_RESET) && timer_match_interrupt;
	endsequence

	sequence s_warm_upper_hit;
		step && warm_mode && (cnt_reg[15:8] == period_reg[15:8])
		&& (cnt_reg[7:0] != period_reg[7:0]);
	endsequence

	a_period_clears: assert property (@(posedge clk) disable iff (srst)
		s_period_step |=> s_match_done) // [RULE3]
		else $error("period match did not clear counter and interrupt");

	a_warm_upper: assert property (@(posedge clk) disable iff (srst)
		s_warm_upper_hit |=> s_match_done) // [RULE15]
		else $error("warm-up match on the upper byte did not end the count");

	a_count_step: assert property (@(posedge clk) disable iff (srst)
		(step && !period_hit) |=> (cnt_reg == $past(cnt_reg) + 16'h0001)) // [RULE1]
		else $error("counter did not advance by one on a step");

	a_load_refused: assert property (@(posedge clk) disable iff (srst)
		(init_load && cascade_start_bit && !flop_flip) |=> $stable(pulse_output_pin)) // [RULE11]
		else $error("initial level load was taken while running");

	a_reset_levels: assert property (@(posedge clk)
		srst |=> (cnt_reg == CPW_CNT_RESET) && !timer_match_interrupt && pulse_output_pin) // [RULE5]
		else $error("reset did not clear counter, request and output flop");

	a_period_low_wr: assert property (@(posedge clk) disable iff (srst)
		period_low_wr |=> (period_reg[7:0] == $past(wr_data))) // [RULE9]
		else $error("period low byte not in effect after write");

	a_period_high_wr: assert property (@(posedge clk) disable iff (srst)
		period_high_wr |=> (period_reg[15:8] == $past(wr_data))) // [RULE9]
		else $error("period high byte not in effect after write");

	a_width_low_wr: assert property (@(posedge clk) disable iff (srst)
		width_low_wr |=> (width_reg[7:0] == $past(wr_data))) // [RULE9]
		else $error("width low byte not in effect after write");

	a_width_high_wr: assert property (@(posedge clk) disable iff (srst)
		width_high_wr |=> (width_reg[15:8] == $past(wr_data))) // [RULE9]
		else $error("width high byte not in effect after write");

	a_range_inside: assert property (@(posedge clk) disable iff (srst)
		((period_reg[15:8] != 8'h00) && (period_reg[15:8] != 8'hff)) |=> warm_range_ok) // [RULE19]
		else $error("period inside the warm-up range not flagged");

	a_range_above: assert property (@(posedge clk) disable iff (srst)
		(period_reg > CPW_WARM_MAX) |=> !warm_range_ok) // [RULE19]
		else $error("period above the warm-up range flagged as valid");

	a_width_toggles: assert property (@(posedge clk) disable iff (srst)
		(step && width_hit && !period_hit) |=> (pulse_output_pin != $past(pulse_output_pin))
		&& (cnt_reg == $past(cnt_reg) + 16'h0001)) // [RULE2]
		else $error("width match did not toggle flop or counter cleared");

	a_stop_holds: assert property (@(posedge clk) disable iff (srst)
		(!cascade_start_bit && !init_load) |=> $stable(pulse_output_pin) && $stable(cnt_reg)) // [RULE11]
		else $error("stopped timer changed output or count");

	a_warm_no_pulse: assert property (@(posedge clk) disable iff (srst)
		(warm_mode && !init_load) |=> $stable(pulse_output_pin)) // [RULE13]
		else $error("warm-up mode toggled the output");

	a_irq_cause: assert property (@(posedge clk) disable iff (srst)
		timer_match_interrupt |-> $past(match_end)) // [RULE16]
		else $error("interrupt without a period match");

	a_pin_inverse: assert property (@(posedge clk) disable iff (srst)
		init_load && !cascade_start_bit |=> pulse_output_pin == !$past(output_flop_initial)) // [RULE5]
		else $error("initial level not loaded inverted on pin");
endmodule // cpw_timer

//--- inc/cpw_pkg.sv
// Notes on behaviour
// [RULE1] Two 8-bit counters chain into one 16-bit up-counter on internal or event clock.
// [RULE2] Width match inverts the output flop; counting continues without clear.
// [RULE3] Period match inverts the flop, clears the counter and pulses the interrupt.
// [RULE4] Event source holds each level at least two machine cycles.
// [RULE5] Output flop loads a software initial level; reset clears it to zero.
// [RULE6] Pulse output pin always drives the inverse of the output flop.
// [RULE7] Software writes low byte then high byte; never one byte alone.
// [RULE8] Software sets the shared port latch to one before pulse output.
// [RULE9] Period and width registers are unbuffered; writes compare immediately.
// [RULE10] Software avoids changing period or width while the counter runs.
// [RULE11] Stopping the counter holds the output pin at its current level.
// [RULE12] Software changes the initial level in a separate write after stopping.
// [RULE13] Warm-up mode has high-to-low and low-to-high clock switch variants.
// [RULE14] Software holds both initial bits at zero in warm-up mode.
// [RULE15] Warm-up match compares only the upper 8 bits of the period.
// [RULE16] Warm-up match after start clears the counter and pulses the interrupt.
// [RULE17] Software enables the low-frequency oscillator before low warm-up.
// [RULE18] Handler stops counter, selects low clock, then disables high oscillator.
// [RULE19] Low warm-up period accepts 0100H to FF00H.
// [RULE20] High warm-up: enable high oscillator; handler stops, selects high, disables low.
package cpw_pkg;
	localparam logic [15:0] CPW_CNT_RESET     = 16'h0000;
	localparam logic [15:0] CPW_REG_RESET     = 16'h0000;
	localparam logic [15:0] CPW_WARM_MIN      = 16'h0100;
	localparam logic [15:0] CPW_WARM_MAX      = 16'hff00;
	localparam int          CPW_HIGH_LSB      = 8;
	localparam logic [1:0]  CPW_MODE_PPG      = 2'h0;
	localparam logic [1:0]  CPW_MODE_WARM_LO  = 2'h1;
	localparam logic [1:0]  CPW_MODE_WARM_HI  = 2'h2;
endpackage

//--- tb/cpw_event_src.sv
`timescale 1ns/1ps
module cpw_event_src (
	// Clock and enable.
	input  wire logic clk,
	input  wire logic en,
	// Event line.
	output logic      event_pin
);
	logic [1:0] cnt_reg = 2'h0;
	initial event_pin = 1'b1;
	always @(posedge clk) begin
		cnt_reg <= cnt_reg + 2'h1;
		if (en && cnt_reg == 2'h3) event_pin <= ~event_pin;
	end
endmodule // cpw_event_src

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, srst = 1, sb = 0, es = 0, tk = 1, fi = 0, il = 0;
	logic pl = 0, ph = 0, wl = 0, wh = 0, ev, irq, pin, rok;
	logic [1:0]  md = 2'h0;
	logic [7:0]  wd = 8'h00;
	logic [15:0] cv, p, w;
	logic [32:0] rows[2] = '{{16'h0005, 16'h0002, 1'b0}, {16'h0009, 16'h0003, 1'b1}};
	int          errors = 0, compares = 0, n;
	initial forever #2.5 clk = ~clk;
	cpw_event_src u_cpw_event_src (.clk(clk), .en(es), .event_pin(ev));
	cpw_timer u_cpw_timer (.clk(clk), .srst(srst), .mode_sel(md), .cascade_start_bit(sb),
		.event_sel(es), .count_tick(tk), .output_flop_initial(fi), .init_load(il),
		.period_low_wr(pl), .period_high_wr(ph), .width_low_wr(wl), .width_high_wr(wh),
		.wr_data(wd), .event_pin(ev), .count_value(cv), .timer_match_interrupt(irq),
		.pulse_output_pin(pin), .warm_range_ok(rok));
	task chk(input string s, input logic [15:0] e, input logic [15:0] v);
		compares++;
		if (v !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", s, e, v);
		end
	endtask
	task finish_test;
		if (errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task rst;
		@(negedge clk) {srst, sb, es, tk} = 4'b1001;
		@(negedge clk) srst = 0;
	endtask
	task wr(input logic [15:0] a, input logic [15:0] b);
		@(negedge clk) {pl, wd} = {1'b1, a[7:0]};
		@(negedge clk) {pl, ph, wd} = {2'b01, a[15:8]};
		@(negedge clk) {ph, wl, wd} = {2'b01, b[7:0]};
		@(negedge clk) {wl, wh, wd} = {2'b01, b[15:8]};
		@(negedge clk) wh = 0;
	endtask
	task wirq(output int k);
		for (k = 0; k < 3000 && irq !== 1'b1; k++) @(negedge clk);
		if (irq !== 1'b1) begin
			errors++;
			finish_test;
		end
	endtask
	initial begin
		repeat (8) @(negedge clk);
		srst = 0;
		chk("pin", 1, pin);
		foreach (rows[k]) begin
			rst;
			{p, w, fi} = rows[k];
			wr(p, w);
			@(negedge clk) il = 1;
			@(negedge clk) {il, sb} = 2'b01;
			chk("pin", {15'h0, ~fi}, pin);
			wirq(n);
			chk("count", 0, cv);
			chk("pin", {15'h0, ~fi}, pin);
			repeat (w + 2) @(negedge clk);
			chk("count", 16'(w + 16'h0002), cv);
			chk("pin", {15'h0, fi}, pin);
			sb = 0;
			repeat (4) @(negedge clk);
			chk("pin", {15'h0, fi}, pin);
		end
		for (int m = 1; m < 3; m++) begin
			rst;
			md = m[1:0];
			fi = 0;
			wr(16'h01ff, 16'h0000);
			chk("range", 1, rok);
			@(negedge clk) sb = 1;
			wirq(n);
			chk("wait", 1, n < 300);
			chk("early", 1, n > 250);
			chk("count", 0, cv);
			chk("pin", 1, pin);
			sb = 0;
			repeat (2) @(negedge clk);
			chk("count", 0, cv);
		end
		rst;
		md = 0;
		wr(16'hff01, 16'h0001);
		chk("range", 0, rok);
		wr(16'h0004, 16'h0001);
		@(negedge clk) {es, tk, sb} = 3'b101;
		@(negedge clk) {il, fi} = 2'b11;
		@(negedge clk) il = 0;
		wirq(n);
		chk("slow", 1, n >= 30);
		chk("count", 0, cv);
		chk("pin", 1, pin);
		finish_test;
	end
endmodule // tb_top
